/* pcir_regs.sv */
`timescale 1ns/1ps
module pcir_regs #(
    parameter int RATE_1HZ_CNT = pcir_pkg::RATE_1HZ_CYCLES,
    parameter int RATE_7HZ_CNT = pcir_pkg::RATE_7HZ_CYCLES,
    parameter int RATE_12HZ5_CNT = pcir_pkg::RATE_12HZ5_CYCLES,
    parameter int RATE_25HZ_CNT = pcir_pkg::RATE_25HZ_CYCLES,
    parameter int CONV_CNT = pcir_pkg::CONV_CYCLES,
    parameter int BOOT_CNT = pcir_pkg::BOOT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [23:0] sensor_pressure,
    input wire logic [15:0] threshold,
    input wire logic [23:0] pressure_offset,
    input wire logic fifo_empty,
    input wire logic fifo_watermark,
    input wire logic fifo_overrun,
    input wire logic out_low_read,
    input wire logic out_high_read,
    input wire logic pressure_high_read,
    output logic [23:0] pressure_out,
    output logic [23:0] reference_out,
    output logic pressure_available_flag,
    output logic power_active,
    output logic [2:0] rate_sel,
    output logic serial_wire_select,
    output logic trim_load,
    output logic soft_restart_pulse,
    output logic irq_pin_out,
    output logic irq_pin_oe
);
    import pcir_pkg::*;

    initial begin
        if (RATE_1HZ_CNT < 2 || RATE_7HZ_CNT < 2 || RATE_12HZ5_CNT < 2 || RATE_25HZ_CNT < 2
            || CONV_CNT < 1 || BOOT_CNT < 1 || CONV_CNT > 65536 || BOOT_CNT > 65536
            || RATE_1HZ_CNT >= 2 ** 27 || RATE_7HZ_CNT >= 2 ** 27
            || RATE_12HZ5_CNT >= 2 ** 27 || RATE_25HZ_CNT >= 2 ** 27) begin
            $error("pcir_regs: count parameters out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic rst_s1_reg, rst_s2_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rstn = rst_s2_reg;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] control_one_reg, control_two_reg, irq_pin_ctrl_reg, routing_reg, event_cfg_reg;
    logic [1:0] event_flags_reg;
    logic [23:0] reference_reg, pressure_out_reg;
    logic pressure_available_reg, hold_reg, half_seen_reg, irq_pin_reg, irq_oe_reg;
    logic [26:0] rate_cnt_reg;
    logic [15:0] conv_cnt_reg, boot_cnt_reg;
    logic converting_reg, booting_reg, boot_wait_reg, sample_reg, soft_restart_reg;
    logic az_pending_reg;

    wire wr_c1 = reg_wr && (reg_addr == ADDR_CONTROL_ONE);
    wire wr_c2 = reg_wr && (reg_addr == ADDR_CONTROL_TWO);
    wire wr_c3 = reg_wr && (reg_addr == ADDR_IRQ_PIN_CTRL);
    wire wr_c4 = reg_wr && (reg_addr == ADDR_IRQ_ROUTING);
    wire wr_cfg = reg_wr && (reg_addr == ADDR_EVENT_CFG);
    wire rd_src = reg_rd && (reg_addr == ADDR_EVENT_SOURCE);
    wire restart_req = wr_c2 && reg_wdata[SOFT_RESTART_BIT] && reg_wdata[REBOOT_BIT];

    wire pwr = control_one_reg[POWER_ACTIVE_BIT];
    wire [2:0] rate = control_one_reg[RATE_SEL_MSB:RATE_SEL_LSB];
    wire differential_enable = control_one_reg[DIFFERENTIAL_ENABLE_BIT];
    wire block_update_hold = control_one_reg[BLOCK_UPDATE_HOLD_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // rate tick; reserved codes run no conversions
    logic [26:0] rate_period;
    assign rate_period = (rate == RATE_1HZ) ? 27'(RATE_1HZ_CNT) :
                         (rate == RATE_7HZ) ? 27'(RATE_7HZ_CNT) :
                         (rate == RATE_12HZ5) ? 27'(RATE_12HZ5_CNT) :
                         (rate == RATE_25HZ) ? 27'(RATE_25HZ_CNT) : 27'h0;
    wire periodic = pwr && (rate_period != 27'h0);
    wire rate_tick = periodic && (rate_cnt_reg == rate_period - 27'h1);
    wire one_shot_start = pwr && (rate == RATE_ONE_SHOT) && control_two_reg[ONE_SHOT_BIT]
                          && !converting_reg;
    wire conv_done = converting_reg && (conv_cnt_reg == 16'(CONV_CNT - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rate_cnt_reg <= 27'h0;
            converting_reg <= 1'b0;
            conv_cnt_reg <= 16'h0;
            sample_reg <= 1'b0;
        end else begin
            rate_cnt_reg <= (!periodic || rate_tick) ? 27'h0 : rate_cnt_reg + 27'h1;
            sample_reg <= rate_tick || conv_done;
            if (one_shot_start) begin
                converting_reg <= 1'b1;
            end else if (conv_done) begin
                converting_reg <= 1'b0;
            end
            conv_cnt_reg <= converting_reg ? conv_cnt_reg + 16'h1 : 16'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reboot waits for the next rate tick (none if not periodic), then copies trimming
    wire boot_go = boot_wait_reg && (rate_tick || !periodic);
    wire boot_done = booting_reg && (boot_cnt_reg == 16'(BOOT_CNT - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_wait_reg <= 1'b0;
            booting_reg <= 1'b0;
            boot_cnt_reg <= 16'h0;
            soft_restart_reg <= 1'b0;
        end else begin
            soft_restart_reg <= restart_req;
            if (wr_c2 && reg_wdata[REBOOT_BIT] && !booting_reg) begin
                boot_wait_reg <= 1'b1;
            end else if (boot_go) begin
                boot_wait_reg <= 1'b0;
            end
            if (boot_go) begin
                booting_reg <= 1'b1;
            end else if (boot_done) begin
                booting_reg <= 1'b0;
            end
            boot_cnt_reg <= booting_reg ? boot_cnt_reg + 16'h1 : 16'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers; soft restart returns all five writable control registers to power-on values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_one_reg <= RESET_CONTROL_ONE;
            control_two_reg <= RESET_CONTROL_TWO;
            irq_pin_ctrl_reg <= RESET_IRQ_PIN_CTRL;
            routing_reg <= RESET_IRQ_ROUTING;
            event_cfg_reg <= RESET_EVENT_CFG;
        end else if (soft_restart_reg) begin
            control_one_reg <= RESET_CONTROL_ONE;
            control_two_reg <= RESET_CONTROL_TWO;
            irq_pin_ctrl_reg <= RESET_IRQ_PIN_CTRL;
            routing_reg <= RESET_IRQ_ROUTING;
            event_cfg_reg <= RESET_EVENT_CFG;
        end else begin
            if (wr_c1) begin
                control_one_reg <= reg_wdata;
            end else begin
                control_one_reg[REFERENCE_RESTORE_BIT] <= 1'b0;
            end
            if (wr_c2) begin
                control_two_reg <= reg_wdata & ~(8'(1) << SOFT_RESTART_BIT);
            end else begin
                if (conv_done) begin
                    control_two_reg[ONE_SHOT_BIT] <= 1'b0;
                end
                if (boot_done) begin
                    control_two_reg[REBOOT_BIT] <= 1'b0;
                end
            end
            if (wr_c3) begin
                irq_pin_ctrl_reg <= reg_wdata & IRQ_PIN_CTRL_MASK;
            end
            if (wr_c4) begin
                routing_reg <= reg_wdata & IRQ_ROUTING_MASK;
            end
            if (wr_cfg) begin
                event_cfg_reg <= reg_wdata & EVENT_CFG_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference and output data path
    wire az_rise = wr_c2 && reg_wdata[AUTO_ZERO_BIT] && !control_two_reg[AUTO_ZERO_BIT];
    wire az_on = control_two_reg[AUTO_ZERO_BIT];
    wire [23:0] pressure_calc = az_on ? sensor_pressure - reference_reg : sensor_pressure;
    wire out_read = out_low_read || out_high_read;
    wire frozen = block_update_hold && hold_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reference_reg <= 24'h0;
            az_pending_reg <= 1'b0;
            pressure_out_reg <= 24'h0;
            pressure_available_reg <= 1'b0;
            hold_reg <= 1'b0;
            half_seen_reg <= 1'b0;
        end else begin
            az_pending_reg <= az_rise || (az_pending_reg && !sample_reg);
            if (control_one_reg[REFERENCE_RESTORE_BIT]) begin
                reference_reg <= pressure_offset;
            end else if (az_pending_reg && sample_reg) begin
                reference_reg <= sensor_pressure;
            end
            if (sample_reg && !frozen) begin
                pressure_out_reg <= pressure_calc;
            end
            // set wins over the read-clear
            if (sample_reg) begin
                pressure_available_reg <= 1'b1;
            end else if (pressure_high_read) begin
                pressure_available_reg <= 1'b0;
            end
            // hold from first half read until the other half is read
            if (!block_update_hold) begin
                hold_reg <= 1'b0;
                half_seen_reg <= 1'b0;
            end else if (out_read && !hold_reg) begin
                hold_reg <= 1'b1;
                half_seen_reg <= out_high_read;
            end else if (hold_reg && ((half_seen_reg && out_low_read)
                                      || (!half_seen_reg && out_high_read))) begin
                hold_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // threshold events: unsigned sixteenths of hPa, diff pressure in 1/4096 hPa
    wire signed [24:0] diff_s = {pressure_calc[23], pressure_calc};
    wire signed [24:0] ths_s = $signed({1'b0, threshold, 8'h00});
    wire cmp_high = differential_enable && event_cfg_reg[HIGH_EVENT_ENABLE_BIT] && (diff_s > ths_s);
    wire cmp_low = differential_enable && event_cfg_reg[LOW_EVENT_ENABLE_BIT] && (diff_s < -ths_s);
    wire latch = event_cfg_reg[LATCH_REQUEST_BIT];
    wire [1:0] cmp_now = {cmp_low, cmp_high};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_flags_reg <= 2'h0;
        end else if (latch) begin
            event_flags_reg <= cmp_now | (rd_src ? 2'h0 : event_flags_reg);
        end else begin
            event_flags_reg <= cmp_now;
        end
    end
    wire irq_active = |event_flags_reg;
    wire [7:0] source_val = {5'h00, irq_active, event_flags_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt pin
    wire [1:0] src_sel = {irq_pin_ctrl_reg[PIN_SOURCE_SEL_HI_BIT],
                          irq_pin_ctrl_reg[PIN_SOURCE_SEL_LO_BIT]};
    wire data_sig = (routing_reg[ROUTE_FIFO_EMPTY_BIT] && fifo_empty)
                    || (routing_reg[ROUTE_WATERMARK_BIT] && fifo_watermark)
                    || (routing_reg[ROUTE_OVERRUN_BIT] && fifo_overrun)
                    || (routing_reg[ROUTE_DATA_READY_BIT] && pressure_available_reg);
    wire irq_level = (src_sel == SRC_DATA) ? data_sig :
                     (src_sel == SRC_HIGH) ? event_flags_reg[HIGH_EVENT_FLAG_BIT] :
                     (src_sel == SRC_LOW) ? event_flags_reg[LOW_EVENT_FLAG_BIT] :
                     irq_active;
    wire pin_val = irq_level ^ irq_pin_ctrl_reg[IRQ_POLARITY_BIT];
    // open drain only ever pulls low; high level comes from the board
    wire open_drain = irq_pin_ctrl_reg[IRQ_DRIVER_TYPE_BIT];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_pin_reg <= 1'b0;
            irq_oe_reg <= 1'b1;
        end else begin
            irq_pin_reg <= open_drain ? 1'b0 : pin_val;
            irq_oe_reg <= open_drain ? !pin_val : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, registered; unmapped addresses read zero
    logic [7:0] rdata_mux;
    assign rdata_mux = (reg_addr == ADDR_CONTROL_ONE) ? control_one_reg :
                       (reg_addr == ADDR_CONTROL_TWO) ? control_two_reg :
                       (reg_addr == ADDR_IRQ_PIN_CTRL) ? irq_pin_ctrl_reg :
                       (reg_addr == ADDR_IRQ_ROUTING) ? routing_reg :
                       (reg_addr == ADDR_EVENT_CFG) ? event_cfg_reg :
                       (reg_addr == ADDR_EVENT_SOURCE) ? source_val : 8'h00;
    logic [7:0] rdata_reg;
    logic trim_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
            trim_reg <= 1'b0;
        end else begin
            if (reg_rd) begin
                rdata_reg <= rdata_mux;
            end
            trim_reg <= boot_done;
        end
    end

    assign reg_rdata = rdata_reg;
    assign pressure_out = pressure_out_reg;
    assign reference_out = reference_reg;
    assign pressure_available_flag = pressure_available_reg;
    assign power_active = control_one_reg[POWER_ACTIVE_BIT];
    assign rate_sel = control_one_reg[RATE_SEL_MSB:RATE_SEL_LSB];
    assign serial_wire_select = control_one_reg[SERIAL_WIRE_SELECT_BIT];
    assign trim_load = trim_reg;
    assign soft_restart_pulse = soft_restart_reg;
    assign irq_pin_out = irq_pin_reg;
    assign irq_pin_oe = irq_oe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    no_sample_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !pwr |=> !sample_reg)
        else $error("sample while powered down");
    shot_clears_a: assert property (@(posedge clk) disable iff (!rstn)
        conv_done && !wr_c2 && !soft_restart_reg |=> !control_two_reg[ONE_SHOT_BIT] && sample_reg)
        else $error("one-shot did not finish");
    restore_ref_a: assert property (@(posedge clk) disable iff (!rstn)
        control_one_reg[REFERENCE_RESTORE_BIT] && !wr_c1
        |=> reference_reg == $past(pressure_offset) && !control_one_reg[REFERENCE_RESTORE_BIT])
        else $error("reference restore failed");
    freeze_out_a: assert property (@(posedge clk) disable iff (!rstn)
        frozen |=> $stable(pressure_out_reg))
        else $error("output changed while frozen");
    avail_set_a: assert property (@(posedge clk) disable iff (!rstn)
        sample_reg |=> pressure_available_reg)
        else $error("available flag not set");
    src_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        rd_src && latch && !wr_cfg && !soft_restart_reg && cmp_now == 2'h0
        |=> event_flags_reg == 2'h0)
        else $error("source read did not clear");
    active_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        source_val[IRQ_ACTIVE_FLAG_BIT] == (event_flags_reg != 2'h0))
        else $error("active flag mismatch");
    pin_polarity_a: assert property (@(posedge clk) disable iff (!rstn)
        !open_drain |=> irq_pin_reg == ($past(irq_level) ^ $past(irq_pin_ctrl_reg[IRQ_POLARITY_BIT])))
        else $error("pin level wrong");
    open_drain_a: assert property (@(posedge clk) disable iff (!rstn)
        open_drain |=> !irq_pin_reg)
        else $error("open drain drove high");
    no_diff_a: assert property (@(posedge clk) disable iff (!rstn)
        !differential_enable && !latch |=> event_flags_reg == 2'h0)
        else $error("event without differential enable");
endmodule

/* pcir_pkg.sv */
package pcir_pkg;
    localparam logic [6:0] ADDR_CONTROL_ONE = 7'h20;
    localparam logic [6:0] ADDR_CONTROL_TWO = 7'h21;
    localparam logic [6:0] ADDR_IRQ_PIN_CTRL = 7'h22;
    localparam logic [6:0] ADDR_IRQ_ROUTING = 7'h23;
    localparam logic [6:0] ADDR_EVENT_CFG = 7'h24;
    localparam logic [6:0] ADDR_EVENT_SOURCE = 7'h25;
    localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RESET_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RESET_IRQ_PIN_CTRL = 8'h00;
    localparam logic [7:0] RESET_IRQ_ROUTING = 8'h00;
    localparam logic [7:0] RESET_EVENT_CFG = 8'h00;
    localparam logic [7:0] RESET_EVENT_SOURCE = 8'h00;
    // control_one fields
    localparam int POWER_ACTIVE_BIT = 7;
    localparam int RATE_SEL_MSB = 6;
    localparam int RATE_SEL_LSB = 4;
    localparam int DIFFERENTIAL_ENABLE_BIT = 3;
    localparam int BLOCK_UPDATE_HOLD_BIT = 2;
    localparam int REFERENCE_RESTORE_BIT = 1;
    localparam int SERIAL_WIRE_SELECT_BIT = 0;
    // control_two fields
    localparam int REBOOT_BIT = 7;
    localparam int SOFT_RESTART_BIT = 2;
    localparam int AUTO_ZERO_BIT = 1;
    localparam int ONE_SHOT_BIT = 0;
    // interrupt pin control fields
    localparam int IRQ_POLARITY_BIT = 7;
    localparam int IRQ_DRIVER_TYPE_BIT = 6;
    localparam int PIN_SOURCE_SEL_HI_BIT = 1;
    localparam int PIN_SOURCE_SEL_LO_BIT = 0;
    localparam logic [7:0] IRQ_PIN_CTRL_MASK = 8'hC3;
    // routing fields
    localparam int ROUTE_FIFO_EMPTY_BIT = 3;
    localparam int ROUTE_WATERMARK_BIT = 2;
    localparam int ROUTE_OVERRUN_BIT = 1;
    localparam int ROUTE_DATA_READY_BIT = 0;
    localparam logic [7:0] IRQ_ROUTING_MASK = 8'h0F;
    // event config / source fields
    localparam int LATCH_REQUEST_BIT = 2;
    localparam int LOW_EVENT_ENABLE_BIT = 1;
    localparam int HIGH_EVENT_ENABLE_BIT = 0;
    localparam logic [7:0] EVENT_CFG_MASK = 8'h07;
    localparam int IRQ_ACTIVE_FLAG_BIT = 2;
    localparam int LOW_EVENT_FLAG_BIT = 1;
    localparam int HIGH_EVENT_FLAG_BIT = 0;
    // rate codes, pin source select codes, offset reset value
    localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
    localparam logic [2:0] RATE_1HZ = 3'h1;
    localparam logic [2:0] RATE_7HZ = 3'h2;
    localparam logic [2:0] RATE_12HZ5 = 3'h3;
    localparam logic [2:0] RATE_25HZ = 3'h4;
    localparam logic [1:0] SRC_DATA = 2'h0;
    localparam logic [1:0] SRC_HIGH = 2'h1;
    localparam logic [1:0] SRC_LOW = 2'h2;
    localparam logic [1:0] SRC_EITHER = 2'h3;
    localparam logic [23:0] PRESSURE_OFFSET_RESET = 24'h000038;
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int RATE_1HZ_CYCLES = CLK_HZ / 1;
    localparam int RATE_7HZ_CYCLES = CLK_HZ / 7;
    localparam int RATE_12HZ5_CYCLES = (CLK_HZ * 2) / 25;
    localparam int RATE_25HZ_CYCLES = CLK_HZ / 25;
    localparam int CONV_TIME_US = 40;
    localparam int CONV_CYCLES = (CONV_TIME_US * (CLK_HZ / 1000000));
    localparam int BOOT_TIME_US = 20;
    localparam int BOOT_CYCLES = (BOOT_TIME_US * (CLK_HZ / 1000000));
endpackage

/* pcir_pin_model.sv */
`timescale 1ns/1ps
module pcir_pin_model (
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    // board pull-up holds the line high when nobody drives it
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

/* test_pressure_ctrl_interrupt_regs.sv */
`timescale 1ns/1ps
module test_pressure_ctrl_interrupt_regs;
    import pcir_pkg::*;
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, rd_lo = 0, rd_hi = 0, rd_ph = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, rd, reg_rdata;
    logic [23:0] sensor = 24'h000000, offset = 24'h123456, pressure_out, reference_out;
    logic [15:0] threshold = 16'h0010;
    logic [2:0] fifo_lv = 3'h0, rate_sel;
    logic avail, power_active, wire_sel, trim_load, restart_pulse, pin_out, pin_oe, pin_lvl;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n;
    pcir_regs #(.RATE_1HZ_CNT(40), .RATE_7HZ_CNT(30), .RATE_12HZ5_CNT(25),
        .RATE_25HZ_CNT(20), .CONV_CNT(4), .BOOT_CNT(4)) pcir_regs_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sensor_pressure(sensor), .threshold(threshold), .pressure_offset(offset),
        .fifo_empty(fifo_lv[2]), .fifo_watermark(fifo_lv[1]), .fifo_overrun(fifo_lv[0]),
        .out_low_read(rd_lo), .out_high_read(rd_hi), .pressure_high_read(rd_ph),
        .pressure_out(pressure_out), .reference_out(reference_out),
        .pressure_available_flag(avail), .power_active(power_active), .rate_sel(rate_sel),
        .serial_wire_select(wire_sel), .trim_load(trim_load),
        .soft_restart_pulse(restart_pulse), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));
    pcir_pin_model pcir_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_lvl));
    ////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task finish_test();
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(string nm, logic [23:0] e, logic [23:0] s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(logic [6:0] a, logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge clk);
        #1 reg_wr = 0;
    endtask
    task rdr(logic [6:0] a);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1;
        @(posedge clk);
        #1 reg_rd = 0;
        rd = reg_rdata;
    endtask
    // one-cycle pulse on the output read strobes {high byte, high half, low half}
    task strobe(logic [2:0] s);
        @(posedge clk);
        #1 {rd_ph, rd_hi, rd_lo} = s;
        @(posedge clk);
        #1 {rd_ph, rd_hi, rd_lo} = 3'h0;
    endtask
    // register effect plus registered pin stage
    task settle(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        settle(5);
        resetn = 1;
        settle(3);
        for (int i = 0; i < 6; i++) begin
            rdr(7'h20 + i[6:0]);
            chk("reset value", 24'h0, {16'h0, rd});
        end
        rdr(7'h30);
        chk("unmapped", 24'h0, {16'h0, rd});
        wr(ADDR_IRQ_PIN_CTRL, 8'hFF);
        rdr(ADDR_IRQ_PIN_CTRL);
        chk("pin ctrl", 24'hC3, {16'h0, rd});
        wr(ADDR_IRQ_ROUTING, 8'hFF);
        rdr(ADDR_IRQ_ROUTING);
        chk("routing", 24'h0F, {16'h0, rd});
        for (int r = 1; r < 5; r++) begin
            wr(ADDR_CONTROL_ONE, {1'b1, r[2:0], 4'h1});
            settle(1);
            chk("rate", 24'(r), {21'h0, rate_sel});
        end
        chk("power", 24'h1, {23'h0, power_active});
        chk("wire sel", 24'h1, {23'h0, wire_sel});
        // one-shot conversion and data-ready routing
        wr(ADDR_CONTROL_ONE, 8'h80);
        wr(ADDR_IRQ_ROUTING, 8'h01);
        wr(ADDR_IRQ_PIN_CTRL, 8'h00);
        sensor = 24'h0ABCDE;
        wr(ADDR_CONTROL_TWO, 8'h01);
        settle(20);
        rdr(ADDR_CONTROL_TWO);
        chk("one shot clear", 24'h0, {16'h0, rd});
        chk("available", 24'h1, {23'h0, avail});
        chk("pressure", 24'h0ABCDE, pressure_out);
        chk("drdy pin", 24'h1, {23'h0, pin_out});
        wr(ADDR_IRQ_PIN_CTRL, 8'h80);
        settle(3);
        chk("low active", 24'h0, {23'h0, pin_out});
        wr(ADDR_IRQ_PIN_CTRL, 8'hC0);
        settle(3);
        chk("drain low", 24'h0, {23'h0, pin_lvl});
        wr(ADDR_IRQ_PIN_CTRL, 8'h40);
        settle(3);
        chk("drain released", 24'h1, {23'h0, pin_lvl});
        wr(ADDR_IRQ_PIN_CTRL, 8'h00);
        for (int i = 0; i < 3; i++) begin
            fifo_lv = 3'h1 << i;
            wr(ADDR_IRQ_ROUTING, 8'h02 << i);
            settle(3);
            chk("routed", 24'h1, {23'h0, pin_out});
            wr(ADDR_IRQ_ROUTING, 8'h02 << ((i + 1) % 3));
            settle(3);
            chk("unrouted", 24'h0, {23'h0, pin_out});
        end
        fifo_lv = 3'h0;
        // threshold events, first with differential circuit off
        wr(ADDR_CONTROL_ONE, 8'h90);
        wr(ADDR_EVENT_CFG, 8'h01);
        wr(ADDR_IRQ_PIN_CTRL, 8'h01);
        sensor = 24'h002000;
        settle(100);
        chk("diff off", 24'h0, {23'h0, pin_out});
        wr(ADDR_CONTROL_ONE, 8'h98);
        settle(100);
        chk("high event", 24'h1, {23'h0, pin_out});
        rdr(ADDR_EVENT_SOURCE);
        chk("high source", 24'h05, {16'h0, rd});
        // threshold equal to pressure is not above it
        threshold = 16'h0020;
        settle(3);
        chk("at threshold", 24'h0, {23'h0, pin_out});
        threshold = 16'h0010;
        wr(ADDR_EVENT_CFG, 8'h00);
        settle(3);
        chk("high disabled", 24'h0, {23'h0, pin_out});
        sensor = 24'hFFE000;
        wr(ADDR_EVENT_CFG, 8'h02);
        wr(ADDR_IRQ_PIN_CTRL, 8'h02);
        settle(100);
        chk("low event", 24'h1, {23'h0, pin_out});
        rdr(ADDR_EVENT_SOURCE);
        chk("low source", 24'h06, {16'h0, rd});
        // latched flag outlives its cause until read
        sensor = 24'h000000;
        settle(100);
        wr(ADDR_EVENT_CFG, 8'h07);
        rdr(ADDR_EVENT_SOURCE);
        sensor = 24'h002000;
        settle(100);
        sensor = 24'h000000;
        settle(100);
        rdr(ADDR_EVENT_SOURCE);
        chk("latched", 24'h05, {16'h0, rd});
        rdr(ADDR_EVENT_SOURCE);
        chk("read clear", 24'h0, {16'h0, rd});
        sensor = 24'h100000;
        wr(ADDR_CONTROL_TWO, 8'h02);
        settle(100);
        chk("auto zero ref", 24'h100000, reference_out);
        chk("auto zero out", 24'h000000, pressure_out);
        wr(ADDR_CONTROL_TWO, 8'h00);
        wr(ADDR_CONTROL_ONE, 8'h02);
        settle(3);
        chk("restore", 24'h123456, reference_out);
        rdr(ADDR_CONTROL_ONE);
        chk("restore clear", 24'h0, {16'h0, rd});
        // powered down, so no sample can re-set the flag
        strobe(3'h4);
        chk("available clear", 24'h0, {23'h0, avail});
        // block update: low half read freezes until high half read
        sensor = 24'h000111;
        wr(ADDR_CONTROL_ONE, 8'h94);
        settle(100);
        strobe(3'h1);
        sensor = 24'h000222;
        settle(100);
        chk("bdu hold", 24'h000111, pressure_out);
        strobe(3'h2);
        settle(100);
        chk("bdu release", 24'h000222, pressure_out);
        wr(ADDR_CONTROL_ONE, 8'h00);
        wr(ADDR_CONTROL_TWO, 8'h80);
        n = 0;
        while (trim_load !== 1'b1 && n < 50) begin
            settle(1);
            n++;
        end
        chk("trim load", 24'h1, {23'h0, trim_load});
        settle(2);
        rdr(ADDR_CONTROL_TWO);
        chk("reboot clear", 24'h0, {16'h0, rd});
        wr(ADDR_IRQ_PIN_CTRL, 8'h43);
        // pulse stands only in the cycle right after the write edge
        wr(ADDR_CONTROL_TWO, 8'h84);
        chk("restart", 24'h1, {23'h0, restart_pulse});
        settle(3);
        rdr(ADDR_IRQ_PIN_CTRL);
        chk("restart cfg", 24'h0, {16'h0, rd});
        finish_test();
    end
endmodule
